// *** pios_cmd_monitor.sv ***
// Port-level checker of the command unit.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module pios_cmd_monitor (
    input wire       ref_clk_i,
    input wire       rstn_i,
    input wire       host_wr_i,
    input wire       host_a0_i,
    input wire       host_rd_i,
    input wire       obf_o,
    input wire       ibf_o,
    input wire       busy_o,
    input wire       cd_o,
    input wire       host_irq_o,
    input wire       per_cmd_o,
    input wire [4:0] per_code_o,
    input wire       per_abort_o,
    input wire [3:0] per_irq_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    ibf_set_a: assert property (
        host_wr_i && !ibf_o |=> ibf_o) else $error("input flag not set");
    cd_follow_a: assert property (
        host_wr_i && !ibf_o |=> cd_o == $past(host_a0_i)) else $error("cd flag wrong");
    obf_clear_a: assert property (
        host_rd_i && !busy_o && !ibf_o |=> !obf_o) else $error("output flag kept");
    busy_cause_a: assert property (
        $rose(busy_o) |-> $past(ibf_o)) else $error("busy without a byte");
    abort_busy_a: assert property (
        per_abort_o |=> busy_o [*3]) else $error("reset not busy");
    code_range_a: assert property (
        per_cmd_o |-> per_code_o >= 5'h10 && per_code_o <= 5'h19) else $error("bad dispatch");
    dispatch_busy_a: assert property (
        per_cmd_o |-> busy_o) else $error("dispatch while idle");
    irq_line_a: assert property (
        per_irq_i != 4'h0 |-> ##2 host_irq_o) else $error("host line not raised");
endmodule

bind pios_cmd_unit pios_cmd_monitor mon_u (.ref_clk_i, .rstn_i, .host_wr_i,
    .host_a0_i, .host_rd_i, .obf_o, .ibf_o, .busy_o, .cd_o, .host_irq_o,
    .per_cmd_o, .per_code_o, .per_abort_o, .per_irq_i);

// *** pios_cmd_unit.v ***
// Command decoder and system-command executor of the parallel I/O
// subsystem, behind a one-byte host data buffer with status flags.
// Assumes the host bus logic and the peripheral handlers run on
// ref_clk_i; their strobes are one-cycle pulses on that clock.
//
// Notes on behaviour
// - Decode the eleven system command codes
// - Reserved codes flag illegal command, not run
// - Codes 10h-19h go to peripheral handlers
// - System commands ignore bit 7, no completion
// - Soft reset aborts, reinitialises, stays busy 100ms
// - Device error clear accepted, does nothing
// - Subsystem status to output buffer as data
// - Bad clear mask sets flag, status read clears
// - Stray data byte discarded, flag set
// - Undefined command flagged, status read clears
// - No-response sets summary error, device status clears
// - Device status byte to output buffer as data
// - Completion sets interrupt bit, clear commands reset
// - Peripheral error bit, cleared by status read
// - Selective clear uses mask, drops host line
// - Clear-all drops every interrupt and line
// - Force raises host line until clear-all
// - Echo returns complemented byte after 2ms
// - ROM checksum, pass zeros or fail ones
// - RAM write/read test, stop on mismatch
// - Enable byte sets persistent per-peripheral enables
// - Enable acts as request-interrupt bit always
// - Busy set on accept, cleared on completion
// - Command/data flag follows port, marks output
// - Full flags set by writer, cleared by reader
// - Command byte: code, control, request-interrupt
`timescale 1ns/1ns
`include "pios_regs.vh"

module pios_cmd_unit #(
    parameter integer RESET_CYC = `PIOS_RESET_MS * `PIOS_CLK_KHZ,
    parameter integer ECHO_CYC  = `PIOS_ECHO_MS * `PIOS_CLK_KHZ,
    parameter integer CSUM_CYC  = `PIOS_CSUM_MS * `PIOS_CLK_KHZ
) (
    input  wire       ref_clk_i,
    input  wire       rstn_i,
    input  wire       host_wr_i,
    input  wire       host_a0_i,
    input  wire [7:0] host_wdata_i,
    input  wire       host_rd_i,
    output wire [7:0] host_rdata_o,
    output wire       obf_o,
    output wire       ibf_o,
    output wire       busy_o,
    output wire       cd_o,
    output wire       host_irq_o,
    output wire       per_cmd_o,
    output wire [4:0] per_code_o,
    output wire [1:0] per_ctl_o,
    output wire       per_rqi_o,
    output wire       per_wr_o,
    output wire [7:0] per_wdata_o,
    output wire       per_abort_o,
    input  wire       per_rvalid_i,
    input  wire [7:0] per_rdata_i,
    input  wire       per_rcd_i,
    input  wire       per_done_i,
    input  wire [3:0] per_irq_i,
    input  wire [3:0] per_err_i,
    input  wire       per_noresp_i
);

    // ************************************************************
    // States and storage
    // ************************************************************
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_WDATA = 3'd1;
    localparam [2:0] S_PER   = 3'd2;
    localparam [2:0] S_TIME  = 3'd3;
    localparam [2:0] S_RAMW  = 3'd4;
    localparam [2:0] S_RAMR  = 3'd5;

    reg  [2:0]  state_ff;
    reg  [4:0]  op_ff;
    reg  [7:0]  in_ff;
    reg         in_cd_ff;
    reg         ibf_ff;
    reg  [7:0]  out_ff;
    reg         obf_ff;
    reg         cd_ff;
    reg         out_sys_ff;
    reg         out_dev_ff;
    reg         busy_ff;
    reg         ill_mask_ff;
    reg         ill_data_ff;
    reg         ill_cmd_ff;
    reg         dev_err_sum_ff;
    reg  [3:0]  dev_int_ff;
    reg  [3:0]  dev_err_ff;
    reg  [3:0]  int_en_ff;
    reg         force_ff;
    reg         irq_line_ff;
    reg         host_irq_ff;
    reg         per_cmd_ff;
    reg  [4:0]  per_code_ff;
    reg  [1:0]  per_ctl_ff;
    reg         per_rqi_ff;
    reg         per_wr_ff;
    reg  [7:0]  per_wdata_ff;
    reg         per_abort_ff;
    reg  [31:0] timer_ff;
    reg  [7:0]  echo_ff;
    reg  [7:0]  sum_ff;
    reg  [4:0]  rom_idx_ff;
    reg  [5:0]  ram_addr_ff;
    reg  [7:0]  ram [0:63];

    // Host reads that clear sticky flags of the byte they fetch
    wire rd_sys = host_rd_i & obf_ff & out_sys_ff;
    wire rd_dev = host_rd_i & obf_ff & out_dev_ff;
    wire [7:0] sys_byte = {4'h0, dev_err_sum_ff, ill_cmd_ff, ill_data_ff, ill_mask_ff};
    wire [7:0] dev_byte = {dev_err_ff, dev_int_ff};
    wire [7:0] ram_pat  = {2'b00, ram_addr_ff} ^ `PIOS_RAM_PATTERN;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Program image; the last entry makes the byte sum come to zero
    function [7:0] rom_byte;
        input [3:0] a;
        begin
            rom_byte = (a == `PIOS_ROM_LAST) ? 8'h97 : {4'h0, a};
        end
    endfunction

    // Peripheral index from the command code
    function [1:0] per_idx;
        input [4:0] c;
        begin
            per_idx = (c[3:1] < 3'd3) ? c[2:1] : 2'd3;
        end
    endfunction

    // Device loads the output buffer and marks its kind
    task put_out;
        input [7:0] d;
        input       c;
        begin
            out_ff     <= d;
            obf_ff     <= 1'b1;
            cd_ff      <= c;
            out_sys_ff <= 1'b0;
            out_dev_ff <= 1'b0;
        end
    endtask

    // Ends a command and reopens the command entry
    task finish;
        begin
            busy_ff  <= 1'b0;
            state_ff <= S_IDLE;
        end
    endtask

    // Accepts one command byte
    task start_cmd;
        input [7:0] b;
        begin
            op_ff    <= b[`PIOS_CODE_MSB:0];
            busy_ff  <= 1'b1;
            state_ff <= S_IDLE;
            if (b[`PIOS_CODE_MSB]) begin
                if (b[`PIOS_CODE_MSB:0] <= `PIOS_PER_LAST) begin
                    per_cmd_ff  <= 1'b1;
                    per_code_ff <= b[`PIOS_CODE_MSB:0];
                    per_ctl_ff  <= b[`PIOS_CTL_MSB:`PIOS_CTL_LSB];
                    per_rqi_ff  <= b[`PIOS_RQI_BIT] | int_en_ff[per_idx(b[4:0])];
                    state_ff    <= S_PER;
                end else begin
                    ill_cmd_ff <= 1'b1;
                    busy_ff    <= 1'b0;
                end
            end else begin
                // Bit 7 is never looked at here
                case (b[`PIOS_CODE_MSB:0])
                    `PIOS_SUBSYSTEM_SOFT_RESET: begin
                        per_abort_ff   <= 1'b1;
                        dev_int_ff     <= 4'h0;
                        dev_err_ff     <= 4'h0;
                        int_en_ff      <= 4'h0;
                        force_ff       <= 1'b0;
                        irq_line_ff    <= 1'b0;
                        ill_mask_ff    <= 1'b0;
                        ill_data_ff    <= 1'b0;
                        ill_cmd_ff     <= 1'b0;
                        dev_err_sum_ff <= 1'b0;
                        obf_ff         <= 1'b0;
                        timer_ff       <= RESET_CYC;
                        state_ff       <= S_TIME;
                    end
                    `PIOS_DEVICE_ERROR_CLEAR: begin
                        busy_ff <= 1'b0;
                    end
                    `PIOS_READ_SUBSYSTEM_STATUS: begin
                        put_out(sys_byte, 1'b0);
                        out_sys_ff <= 1'b1;
                        busy_ff    <= 1'b0;
                    end
                    `PIOS_READ_DEVICE_STATUS: begin
                        put_out(dev_byte, 1'b0);
                        out_dev_ff     <= 1'b1;
                        dev_err_sum_ff <= per_noresp_i;
                        busy_ff        <= 1'b0;
                    end
                    `PIOS_CLEAR_SELECTED_INTERRUPTS,
                    `PIOS_SET_INTERRUPT_ENABLES,
                    `PIOS_ECHO_COMPLEMENT_TEST: begin
                        state_ff <= S_WDATA;
                    end
                    `PIOS_CLEAR_ALL_INTERRUPTS: begin
                        dev_int_ff  <= per_irq_i;
                        irq_line_ff <= |per_irq_i;
                        force_ff    <= 1'b0;
                        busy_ff     <= 1'b0;
                    end
                    `PIOS_FORCE_HOST_INTERRUPT: begin
                        force_ff <= 1'b1;
                        busy_ff  <= 1'b0;
                    end
                    `PIOS_ROM_CHECKSUM_TEST: begin
                        sum_ff     <= 8'h00;
                        rom_idx_ff <= 5'h00;
                        timer_ff   <= CSUM_CYC;
                        state_ff   <= S_TIME;
                    end
                    `PIOS_RAM_SELFTEST: begin
                        ram_addr_ff <= 6'h00;
                        state_ff    <= S_RAMW;
                    end
                    default: begin
                        ill_cmd_ff <= 1'b1;
                        busy_ff    <= 1'b0;
                    end
                endcase
            end
        end
    endtask

    // ************************************************************
    // Test RAM write port
    // ************************************************************
    // Kept out of the reset process so the array maps to plain RAM
    always @(posedge ref_clk_i) begin
        if (state_ff == S_RAMW) begin
            ram[ram_addr_ff] <= ram_pat;
        end
    end

    // ************************************************************
    // Buffer, flags and command sequencer
    // ************************************************************
    // Defaults first; later assignments in the case win, so any
    // event set below beats the clear that the default applies
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_ff       <= S_IDLE;
            op_ff          <= 5'h00;
            in_ff          <= 8'h00;
            in_cd_ff       <= 1'b0;
            ibf_ff         <= 1'b0;
            out_ff         <= 8'h00;
            obf_ff         <= 1'b0;
            cd_ff          <= 1'b0;
            out_sys_ff     <= 1'b0;
            out_dev_ff     <= 1'b0;
            busy_ff        <= 1'b0;
            ill_mask_ff    <= 1'b0;
            ill_data_ff    <= 1'b0;
            ill_cmd_ff     <= 1'b0;
            dev_err_sum_ff <= 1'b0;
            dev_int_ff     <= 4'h0;
            dev_err_ff     <= 4'h0;
            int_en_ff      <= 4'h0;
            force_ff       <= 1'b0;
            irq_line_ff    <= 1'b0;
            host_irq_ff    <= 1'b0;
            per_cmd_ff     <= 1'b0;
            per_code_ff    <= 5'h00;
            per_ctl_ff     <= 2'b00;
            per_rqi_ff     <= 1'b0;
            per_wr_ff      <= 1'b0;
            per_wdata_ff   <= 8'h00;
            per_abort_ff   <= 1'b0;
            timer_ff       <= 32'd0;
            echo_ff        <= 8'h00;
            sum_ff         <= 8'h00;
            rom_idx_ff     <= 5'h00;
            ram_addr_ff    <= 6'h00;
        end else begin
            per_cmd_ff   <= 1'b0;
            per_wr_ff    <= 1'b0;
            per_abort_ff <= 1'b0;
            host_irq_ff  <= force_ff | irq_line_ff;
            ill_mask_ff    <= ill_mask_ff & ~rd_sys;
            ill_data_ff    <= ill_data_ff & ~rd_sys;
            ill_cmd_ff     <= ill_cmd_ff & ~rd_sys;
            dev_err_sum_ff <= dev_err_sum_ff | per_noresp_i;
            dev_int_ff     <= dev_int_ff | per_irq_i;
            dev_err_ff     <= (dev_err_ff & ~{4{rd_dev}}) | per_err_i;
            irq_line_ff    <= irq_line_ff | (|per_irq_i);
            if (host_rd_i) begin
                obf_ff <= 1'b0;
            end
            // Host writes land only in an empty input buffer
            if (host_wr_i && !ibf_ff) begin
                ibf_ff   <= 1'b1;
                in_ff    <= host_wdata_i;
                in_cd_ff <= host_a0_i;
                cd_ff    <= host_a0_i;
            end
            case (state_ff)
                S_IDLE: begin
                    if (ibf_ff) begin
                        ibf_ff <= 1'b0;
                        if (in_cd_ff) begin
                            start_cmd(in_ff);
                        end else begin
                            ill_data_ff <= 1'b1;
                        end
                    end
                end
                S_WDATA: begin
                    if (ibf_ff) begin
                        ibf_ff <= 1'b0;
                        if (in_cd_ff) begin
                            start_cmd(in_ff);
                        end else if (op_ff == `PIOS_CLEAR_SELECTED_INTERRUPTS) begin
                            dev_int_ff  <= (dev_int_ff & ~in_ff[3:0]) | per_irq_i;
                            irq_line_ff <= |per_irq_i;
                            if (|(in_ff[3:0] & ~dev_int_ff)) begin
                                ill_mask_ff <= 1'b1;
                            end
                            finish;
                        end else if (op_ff == `PIOS_SET_INTERRUPT_ENABLES) begin
                            int_en_ff <= in_ff[3:0];
                            finish;
                        end else begin
                            echo_ff  <= ~in_ff;
                            timer_ff <= ECHO_CYC;
                            state_ff <= S_TIME;
                        end
                    end
                end
                S_PER: begin
                    // A command byte waits here until the handler is done
                    if (ibf_ff && !in_cd_ff) begin
                        ibf_ff       <= 1'b0;
                        per_wr_ff    <= 1'b1;
                        per_wdata_ff <= in_ff;
                    end
                    if (per_rvalid_i) begin
                        put_out(per_rdata_i, per_rcd_i);
                    end
                    if (per_done_i) begin
                        finish;
                    end
                end
                S_TIME: begin
                    if (rom_idx_ff <= {1'b0, `PIOS_ROM_LAST}) begin
                        sum_ff     <= sum_ff + rom_byte(rom_idx_ff[3:0]);
                        rom_idx_ff <= rom_idx_ff + 5'd1;
                    end
                    if (timer_ff != 32'd0) begin
                        timer_ff <= timer_ff - 32'd1;
                    end else begin
                        finish;
                        if (op_ff == `PIOS_ECHO_COMPLEMENT_TEST) begin
                            put_out(echo_ff, 1'b0);
                        end else if (op_ff == `PIOS_ROM_CHECKSUM_TEST) begin
                            if (sum_ff == `PIOS_ROM_SUM) begin
                                put_out(`PIOS_PASS_BYTE, 1'b0);
                            end else begin
                                put_out(`PIOS_FAIL_BYTE, 1'b1);
                            end
                        end
                    end
                end
                S_RAMW: begin
                    state_ff <= S_RAMR;
                end
                S_RAMR: begin
                    // First mismatch ends the walk at once
                    if (ram[ram_addr_ff] != ram_pat) begin
                        put_out(`PIOS_FAIL_BYTE, 1'b1);
                        finish;
                    end else if (ram_addr_ff == `PIOS_RAM_LAST) begin
                        put_out(`PIOS_PASS_BYTE, 1'b0);
                        finish;
                    end else begin
                        ram_addr_ff <= ram_addr_ff + 6'd1;
                        state_ff    <= S_RAMW;
                    end
                end
                default: begin
                    finish;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs, all straight from flip-flops
    // ************************************************************
    assign host_rdata_o = out_ff;
    assign obf_o        = obf_ff;
    assign ibf_o        = ibf_ff;
    assign busy_o       = busy_ff;
    assign cd_o         = cd_ff;
    assign host_irq_o   = host_irq_ff;
    assign per_cmd_o    = per_cmd_ff;
    assign per_code_o   = per_code_ff;
    assign per_ctl_o    = per_ctl_ff;
    assign per_rqi_o    = per_rqi_ff;
    assign per_wr_o     = per_wr_ff;
    assign per_wdata_o  = per_wdata_ff;
    assign per_abort_o  = per_abort_ff;

endmodule

// *** pios_cmd_unit_bench.sv ***
// Bench of the command unit: host port tasks, random bytes, handler model.
// Assumes shortened timing parameters; inputs change on rising edges.
`timescale 1ns/1ns
module pios_cmd_unit_bench;
    logic       ref_clk_i, rstn_i, host_wr_i, host_a0_i, host_rd_i, obf_o, ibf_o;
    logic       busy_o, cd_o, host_irq_o, per_cmd_o, per_rqi_o, per_wr_o, per_abort_o;
    logic       per_done_i, per_noresp_i, per_rvalid_i, per_rcd_i;
    logic [7:0] host_wdata_i, host_rdata_o, per_wdata_o, d, per_rdata_i;
    logic [4:0] per_code_o;
    logic [3:0] per_irq_i, per_err_i, lat;
    logic [1:0] per_ctl_o, fault;
    integer     bad_count, n_compared, seed, i;
    pios_cmd_unit #(.RESET_CYC(20), .ECHO_CYC(10), .CSUM_CYC(30)) dut_u (.ref_clk_i,
        .rstn_i, .host_wr_i, .host_a0_i, .host_wdata_i, .host_rd_i, .host_rdata_o,
        .obf_o, .ibf_o, .busy_o, .cd_o, .host_irq_o, .per_cmd_o, .per_code_o,
        .per_ctl_o, .per_rqi_o, .per_wr_o, .per_wdata_o, .per_abort_o,
        .per_rvalid_i, .per_rdata_i, .per_rcd_i, .per_done_i,
        .per_irq_i, .per_err_i, .per_noresp_i);
    pios_handler_model peer_u (.ref_clk_i, .per_cmd_o, .per_code_o, .per_rqi_o,
        .lat_i(lat), .fault_i(fault), .per_done_i, .per_irq_i, .per_err_i, .per_noresp_i,
        .per_rvalid_i, .per_rdata_i, .per_rcd_i);
    // Device status bit of a peripheral code: reader, punch, printer, programmer
    function automatic [7:0] dev_bit(input [4:0] c);
        dev_bit = 8'h01 << ((c < 5'h12) ? 0 : (c < 5'h14) ? 1 : (c < 5'h16) ? 2 : 3);
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Poll flags at falling edges, bounded: 2 output full, 1 idle, 0 input empty
    task wait_for(input logic [1:0] m);
        integer k;
        k = 0;
        @(negedge ref_clk_i);
        while ((m[1] ? ~obf_o : ibf_o | (m[0] & busy_o)) !== 1'b0 && k < 2000) begin
            @(negedge ref_clk_i);
            k = k + 1;
        end
        if (k == 2000) chk(8'h01, 8'h00);
    endtask
    task wr(input logic a, input logic [7:0] b);
        wait_for({1'b0, a});
        @(posedge ref_clk_i);
        host_a0_i <= a;
        host_wdata_i <= b;
        host_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        host_wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] e, input logic ecd);
        wait_for(2'd2);
        chk(host_rdata_o, e);
        chk({7'h00, cd_o}, {7'h00, ecd});
        @(posedge ref_clk_i);
        host_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        host_rd_i <= 1'b0;
    endtask
    task sys(input logic [7:0] e);
        wr(1'b1, 8'h02);
        rd(e, 1'b0);
    endtask
    task dev(input logic [7:0] e);
        wr(1'b1, 8'h03);
        rd(e, 1'b0);
    endtask
    // Host line is two cycles behind its cause, so let it settle first
    task irq(input logic e);
        wait_for(2'd1);
        repeat (3) @(negedge ref_clk_i);
        chk({7'h00, host_irq_o}, {7'h00, e});
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Generous bound: the sequence needs well under a thousand cycles
    initial begin
        #300000;
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        seed = 32'he3fb;
        {bad_count, n_compared} = 0;
        {rstn_i, host_wr_i, host_a0_i, host_rd_i, host_wdata_i, lat, fault} = 0;
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        sys(8'h00);
        for (i = 0; i < 11; i = i + 1) begin
            d = (i < 5) ? 8'h0b + i[7:0] : 8'h15 + i[7:0];
            wr(1'b1, d | {$random(seed), 5'h00});
            sys(8'h04);
        end
        wr(1'b0, $random(seed));
        sys(8'h02);
        wr(1'b1, 8'h81);
        sys(8'h00);
        $display("test flags done");
        for (i = 0; i < 4; i = i + 1) begin
            d = $random(seed);
            wr(1'b1, 8'h87);
            wr(1'b0, d);
            rd(~d, 1'b0);
        end
        wr(1'b1, 8'h08);
        rd(8'h00, 1'b0);
        wr(1'b1, 8'h09);
        rd(8'h00, 1'b0);
        $display("test selftests done");
        // Latency of at least four lets a data byte reach the punch handler in time
        lat = $random(seed) | 4'h4;
        wr(1'b1, 8'hd0);
        irq(1'b1);
        chk({6'h00, per_ctl_o}, 8'h02);
        chk({7'h00, per_rqi_o}, 8'h01);
        dev(dev_bit(5'h10));
        wr(1'b1, 8'h04);
        wr(1'b0, 8'h03);
        sys(8'h01);
        dev(8'h00);
        irq(1'b0);
        wr(1'b1, 8'h06);
        irq(1'b1);
        wr(1'b1, 8'h04);
        wr(1'b0, 8'h00);
        irq(1'b1);
        d = $random(seed);
        wr(1'b1, 8'h92);
        wr(1'b0, d);
        wr(1'b1, 8'h05);
        chk(per_wdata_o, d);
        irq(1'b0);
        dev(8'h00);
        $display("test interrupts done");
        fault = 2'd1;
        wr(1'b1, 8'h13);
        rd(8'hb3, 1'b1);
        dev(dev_bit(5'h13) << 4);
        dev(8'h00);
        fault = 2'd2;
        wr(1'b1, 8'h19);
        rd(8'hb9, 1'b0);
        sys(8'h08);
        dev(8'h00);
        sys(8'h00);
        fault = 2'd0;
        wr(1'b1, 8'h0a);
        wr(1'b0, 8'h04);
        wr(1'b1, 8'h15);
        rd(8'hb5, 1'b0);
        chk({7'h00, per_rqi_o}, 8'h01);
        dev(dev_bit(5'h15));
        wr(1'b1, 8'h00);
        // The command is taken one edge after the write lands
        repeat (2) @(negedge ref_clk_i);
        chk({7'h00, busy_o}, 8'h01);
        irq(1'b0);
        wr(1'b1, 8'h15);
        rd(8'hb5, 1'b0);
        chk({7'h00, per_rqi_o}, 8'h00);
        dev(8'h00);
        $display("test enables and reset done");
        close_out;
    end
endmodule

// *** pios_handler_model.sv ***
// Behavioural peripheral handlers on the dispatch side of the unit.
// Assumes dispatch fields hold until the next dispatch; odd codes return a byte.
`timescale 1ns/1ns
module pios_handler_model (
    input  wire        ref_clk_i,
    input  wire        per_cmd_o,
    input  wire  [4:0] per_code_o,
    input  wire        per_rqi_o,
    input  wire  [3:0] lat_i,
    input  wire  [1:0] fault_i,
    output logic       per_done_i,
    output logic [3:0] per_irq_i,
    output logic [3:0] per_err_i,
    output logic       per_noresp_i,
    output logic       per_rvalid_i,
    output logic [7:0] per_rdata_i,
    output logic       per_rcd_i
);
    logic [1:0] idx;
    // Finish each command after a latency; faults only when the bench asks
    initial begin
        {per_done_i, per_irq_i, per_err_i, per_noresp_i, per_rvalid_i, per_rdata_i,
         per_rcd_i} = 20'h00000;
        forever begin
            @(posedge ref_clk_i);
            if (per_cmd_o === 1'b1) begin
                idx = (per_code_o < 5'h12) ? 0 : (per_code_o < 5'h14) ? 1 :
                      (per_code_o < 5'h16) ? 2 : 3;
                repeat (lat_i) @(posedge ref_clk_i);
                per_done_i <= 1'b1;
                per_irq_i[idx] <= per_rqi_o;
                per_err_i[idx] <= (fault_i == 2'd1);
                per_noresp_i <= (fault_i == 2'd2);
                per_rvalid_i <= per_code_o[0];
                per_rdata_i  <= {3'h5, per_code_o};
                per_rcd_i    <= per_code_o[1];
                @(posedge ref_clk_i);
                {per_done_i, per_irq_i, per_err_i, per_noresp_i, per_rvalid_i} <= 11'h000;
            end
        end
    end
endmodule

// *** pios_regs.vh ***
// Constants of the parallel I/O subsystem command unit: command codes,
// byte field positions, answer bytes and timing figures.
// Assumes a single 100 MHz system clock; included by its bare name.
`ifndef PIOS_REGS_VH
`define PIOS_REGS_VH

// ************************************************************
// Command byte fields
// ************************************************************
`define PIOS_CODE_MSB       4
`define PIOS_CTL_LSB        5
`define PIOS_CTL_MSB        6
`define PIOS_RQI_BIT        7

// ************************************************************
// System command codes and peripheral code range
// ************************************************************
`define PIOS_SUBSYSTEM_SOFT_RESET      5'h00
`define PIOS_DEVICE_ERROR_CLEAR        5'h01
`define PIOS_READ_SUBSYSTEM_STATUS     5'h02
`define PIOS_READ_DEVICE_STATUS        5'h03
`define PIOS_CLEAR_SELECTED_INTERRUPTS 5'h04
`define PIOS_CLEAR_ALL_INTERRUPTS      5'h05
`define PIOS_FORCE_HOST_INTERRUPT      5'h06
`define PIOS_ECHO_COMPLEMENT_TEST      5'h07
`define PIOS_ROM_CHECKSUM_TEST         5'h08
`define PIOS_RAM_SELFTEST              5'h09
`define PIOS_SET_INTERRUPT_ENABLES     5'h0a
`define PIOS_PER_FIRST                 5'h10
`define PIOS_PER_LAST                  5'h19

// ************************************************************
// Status byte layouts (peripheral index 0 reader, 1 punch,
// 2 printer, 3 programmer), answer bytes and self-test constants
// ************************************************************
`define PIOS_SSB_ILL_MASK   0
`define PIOS_SSB_ILL_DATA   1
`define PIOS_SSB_ILL_CMD    2
`define PIOS_SSB_DEV_ERR    3
`define PIOS_NUM_PER        4
`define PIOS_PASS_BYTE      8'h00
`define PIOS_FAIL_BYTE      8'hff
`define PIOS_RAM_PATTERN    8'h5a
`define PIOS_RAM_LAST       6'h3f
`define PIOS_ROM_LAST       4'hf
`define PIOS_ROM_SUM        8'h00

// ************************************************************
// Timing
// ************************************************************
`define PIOS_CLK_KHZ        100000
`define PIOS_RESET_MS       100
`define PIOS_ECHO_MS        2
`define PIOS_CSUM_MS        100

`endif
